//--- common/tpg_pkg.sv
// Package with register map, field positions, reset values and bus carrier for the GPIO block.
`default_nettype none
package tpg_pkg;

  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_A_DATA      = 8'h05;
  localparam logic [7:0] IDX_PORT_B_DATA      = 8'h06;
  localparam logic [7:0] IDX_PORT_C_DATA      = 8'h07;
  localparam logic [7:0] IDX_INTERRUPT_CTRL   = 8'h0B;
  localparam logic [7:0] IDX_OPTION_CONTROL   = 8'h81;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
  localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
  localparam logic [7:0] IDX_ANALOG_PIN_CFG   = 8'h9F;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_OPTION_CONTROL   = 8'hFF;
  localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3F;
  localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hFF;
  localparam logic [5:0] RST_PORT_C_DIRECTION = 6'h3F;
  localparam logic [2:0] RST_ANALOG_PIN_CFG   = 3'h0;
  localparam logic [5:0] RST_PORT_A_LATCH     = 6'h00;
  localparam logic [7:0] RST_PORT_B_LATCH     = 8'h00;
  localparam logic [5:0] RST_PORT_C_LATCH     = 6'h00;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int POS_PULLUP_ENABLE_N = 7;
  localparam int POS_CHANGE_IRQ_FLAG = 0;
  localparam int POS_OPEN_DRAIN_PIN  = 4;
  localparam int POS_EXT_INT_PIN     = 0;
  localparam int POS_PROG_CLK_PIN    = 6;
  localparam int POS_PROG_DATA_PIN   = 7;
  localparam int POS_CHANGE_LO       = 4;

  // Analog pin configuration codes; other codes leave RA0 and RA1 analog.
  localparam logic [2:0] CFG_ALL_ANALOG = 3'h0;
  localparam logic [2:0] CFG_RA3_REF    = 3'h1;
  localparam logic [2:0] CFG_DIGITAL_A  = 3'h6;
  localparam logic [2:0] CFG_DIGITAL_B  = 3'h7;
  localparam logic [5:0] MASK_ANALOG_ALL = 6'h2F;
  localparam logic [5:0] MASK_ANALOG_REF = 6'h27;
  localparam logic [5:0] MASK_ANALOG_LOW = 6'h03;
  localparam logic [5:0] MASK_ANALOG_NONE = 6'h00;

  // ----------------------------------------------------------------------
  // Wishbone request carrier.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tpg_wb_req_t;

endpackage
`default_nettype wire

//--- logic/tpg_gpio.sv
// Three-port GPIO block with Wishbone register access and port B change detection.
//
// Summary of operation
// [R1] Direction one tristates pin, zero drives latch.
// [R2] Data read returns pins; write loads latch.
// [R3] Port writes merge sampled pins into latch.
// [R4] Bit 4 open-drain, also feeds Timer0 clock.
// [R5] Config field selects digital, analog, reference.
// [R6] Reset: analog pins, reading as zero.
// [R7] Software keeps analog pins' direction bits set.
// [R8] Unimplemented port bits read as zero.
// [R9] Clear option bit 7 enables port B pull-ups.
// [R10] Output pins have their pull-up off.
// [R11] Option resets all ones, pull-ups off.
// [R12] Only input pins RB7..RB4 compare changes.
// [R13] Mismatch against last-read copy sets flag.
// [R14] Change flag wakes device from sleep.
// [R15] Mismatch keeps flag set; access then clear.
// [R16] Software avoids polling port B with interrupt.
// [R17] RB0 doubles as external interrupt input.
// [R18] Programming mode: RB6 clock, RB7 data.
// [R19] Port C: six pins, own direction bits.
// [R20] Enabled peripheral overrides port C direction.
// [R21] No bit ops on port C direction.
// [R22] Enabled peripheral takes pin from GPIO.
// [R23] Pin inputs synchronised before use.
`default_nettype none
module tpg_gpio
  import tpg_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  input  wire tpg_wb_req_t i_wb_req,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  input  wire logic [5:0]  i_pa_pin,
  output logic [5:0]       o_pa_out,
  output logic [5:0]       o_pa_oe,
  output logic             o_timer0_ext_clock_in,
  input  wire logic [7:0]  i_pb_pin,
  output logic [7:0]       o_pb_out,
  output logic [7:0]       o_pb_oe,
  output logic [7:0]       o_pb_pullup,
  output logic             o_ext_int_in,
  input  wire logic        i_prog_mode,
  input  wire logic        i_prog_data_out,
  input  wire logic        i_prog_data_oe,
  output logic             o_prog_clk,
  output logic             o_prog_data,
  input  wire logic [5:0]  i_pc_pin,
  output logic [5:0]       o_pc_out,
  output logic [5:0]       o_pc_oe,
  input  wire logic [5:0]  i_pc_periph_en,
  input  wire logic [5:0]  i_pc_periph_dir_out,
  input  wire logic [5:0]  i_pc_periph_out,
  output logic [5:0]       o_pc_periph_in,
  input  wire logic        i_sleep,
  output logic             o_change_irq_flag,
  output logic             o_wake
);

  // ----------------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------------
  if (ADR_W != 10) begin : g_bad_adr
    $error("ADR_W must equal the carrier address width of 10");
  end

  // ----------------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------------
  logic [5:0] pa_meta_ff;
  logic [5:0] pa_sync_ff;
  logic [7:0] pb_meta_ff;
  logic [7:0] pb_sync_ff;
  logic [5:0] pc_meta_ff;
  logic [5:0] pc_sync_ff;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pa_meta_ff <= '0;
      pa_sync_ff <= '0;
      pb_meta_ff <= '0;
      pb_sync_ff <= '0;
      pc_meta_ff <= '0;
      pc_sync_ff <= '0;
    end else if (i_clk_en) begin
      pa_meta_ff <= i_pa_pin; // R23
      pa_sync_ff <= pa_meta_ff;
      pb_meta_ff <= i_pb_pin; // R23
      pb_sync_ff <= pb_meta_ff;
      pc_meta_ff <= i_pc_pin; // R23
      pc_sync_ff <= pc_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Register storage.
  // ----------------------------------------------------------------------
  logic [5:0] pa_latch_ff;
  logic [7:0] pb_latch_ff;
  logic [5:0] pc_latch_ff;
  logic [5:0] pa_dir_ff;
  logic [7:0] pb_dir_ff;
  logic [5:0] pc_dir_ff;
  logic [7:0] option_ff;
  logic [2:0] pin_cfg_ff;
  logic [3:0] pb_old_ff;
  logic       change_flag_ff;
  logic       ack_ff;
  logic [31:0] rdat_ff;

  logic       access;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic [7:0] wmask;
  logic [7:0] wbyte;

  assign access = i_wb_req.cyc & i_wb_req.stb & ~ack_ff;
  assign wr     = access & i_wb_req.we;
  assign rd     = access & ~i_wb_req.we;
  assign idx    = i_wb_req.adr[ADR_W-1:2];
  assign wmask  = {8{i_wb_req.sel[0]}};
  assign wbyte  = i_wb_req.dat[7:0];

  // ----------------------------------------------------------------------
  // Pin views seen by software.
  // ----------------------------------------------------------------------
  logic [5:0] analog_mask;
  logic [5:0] pa_view;
  logic [7:0] pb_view;
  logic [5:0] pc_view;
  logic [3:0] mismatch;

  always_comb begin
    unique case (pin_cfg_ff) // R5
      CFG_ALL_ANALOG: analog_mask = MASK_ANALOG_ALL;
      CFG_RA3_REF:    analog_mask = MASK_ANALOG_REF;
      CFG_DIGITAL_A,
      CFG_DIGITAL_B:  analog_mask = MASK_ANALOG_NONE;
      default:        analog_mask = MASK_ANALOG_LOW;
    endcase
  end

  // Analog pins read as zero so a floating level never reaches software.
  assign pa_view = pa_sync_ff & ~analog_mask; // R6
  assign pb_view = pb_sync_ff;
  assign pc_view = pc_sync_ff;

  // Outputs are excluded from the comparison so driving them never fires.
  assign mismatch = (pb_view[7:POS_CHANGE_LO] ^ pb_old_ff)
                  & pb_dir_ff[7:POS_CHANGE_LO]; // R12

  // ----------------------------------------------------------------------
  // Port data latches.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pa_latch_ff <= RST_PORT_A_LATCH;
      pb_latch_ff <= RST_PORT_B_LATCH;
      pc_latch_ff <= RST_PORT_C_LATCH;
    end else if (i_clk_en && wr) begin
      // Unselected lanes take the sampled pin levels, as a real RMW would.
      if (idx == IDX_PORT_A_DATA) begin
        pa_latch_ff <= (pa_view & ~wmask[5:0]) | (wbyte[5:0] & wmask[5:0]); // R2 R3
      end
      if (idx == IDX_PORT_B_DATA) begin
        pb_latch_ff <= (pb_view & ~wmask) | (wbyte & wmask); // R2 R3
      end
      if (idx == IDX_PORT_C_DATA) begin
        pc_latch_ff <= (pc_view & ~wmask[5:0]) | (wbyte[5:0] & wmask[5:0]); // R2 R3
      end
    end
  end

  // ----------------------------------------------------------------------
  // Direction, option and configuration registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pa_dir_ff  <= RST_PORT_A_DIRECTION; // R6
      pb_dir_ff  <= RST_PORT_B_DIRECTION;
      pc_dir_ff  <= RST_PORT_C_DIRECTION;
      option_ff  <= RST_OPTION_CONTROL; // R11
      pin_cfg_ff <= RST_ANALOG_PIN_CFG; // R6
    end else if (i_clk_en && wr && i_wb_req.sel[0]) begin
      unique case (idx)
        IDX_PORT_A_DIRECTION: pa_dir_ff  <= wbyte[5:0];
        IDX_PORT_B_DIRECTION: pb_dir_ff  <= wbyte;
        IDX_PORT_C_DIRECTION: pc_dir_ff  <= wbyte[5:0]; // R19
        IDX_OPTION_CONTROL:   option_ff  <= wbyte;
        IDX_ANALOG_PIN_CFG:   pin_cfg_ff <= wbyte[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Port B change detection.
  // ----------------------------------------------------------------------
  logic pb_access;
  logic flag_clear;

  assign pb_access  = access & (idx == IDX_PORT_B_DATA);
  assign flag_clear = wr & (idx == IDX_INTERRUPT_CTRL) & i_wb_req.sel[0]
                    & ~wbyte[POS_CHANGE_IRQ_FLAG];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pb_old_ff <= '0;
    end else if (i_clk_en && pb_access) begin
      pb_old_ff <= pb_view[7:POS_CHANGE_LO]; // R13 R15
    end
  end

  // A live mismatch wins over a clear, so the flag keeps re-arming.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      change_flag_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (|mismatch) begin
        change_flag_ff <= 1'b1; // R13 R15
      end else if (flag_clear) begin
        change_flag_ff <= 1'b0; // R15
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave.
  // ----------------------------------------------------------------------
  logic [7:0] rbyte;

  always_comb begin
    unique case (idx)
      IDX_PORT_A_DATA:      rbyte = {2'b00, pa_view}; // R2 R8
      IDX_PORT_B_DATA:      rbyte = pb_view; // R2
      IDX_PORT_C_DATA:      rbyte = {2'b00, pc_view}; // R8
      IDX_INTERRUPT_CTRL:   rbyte = {7'h00, change_flag_ff};
      IDX_OPTION_CONTROL:   rbyte = option_ff;
      IDX_PORT_A_DIRECTION: rbyte = {2'b00, pa_dir_ff}; // R8
      IDX_PORT_B_DIRECTION: rbyte = pb_dir_ff;
      IDX_PORT_C_DIRECTION: rbyte = {2'b00, pc_dir_ff}; // R8
      IDX_ANALOG_PIN_CFG:   rbyte = {5'h00, pin_cfg_ff};
      default:              rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else if (i_clk_en) begin
      ack_ff  <= access;
      rdat_ff <= rd ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;

  // ----------------------------------------------------------------------
  // Pin drivers, all registered.
  // ----------------------------------------------------------------------
  logic [5:0] pa_out_ff;
  logic [5:0] pa_oe_ff;
  logic [7:0] pb_out_ff;
  logic [7:0] pb_oe_ff;
  logic [7:0] pb_pull_ff;
  logic [5:0] pc_out_ff;
  logic [5:0] pc_oe_ff;
  logic [5:0] nxt_pa_out;
  logic [5:0] nxt_pa_oe;
  logic [7:0] nxt_pb_out;
  logic [7:0] nxt_pb_oe;
  logic [5:0] nxt_pc_dir;

  always_comb begin
    nxt_pa_out = pa_latch_ff;
    nxt_pa_oe  = ~pa_dir_ff; // R1
    // The open-drain pin only ever drives low.
    nxt_pa_out[POS_OPEN_DRAIN_PIN] = 1'b0; // R4
    nxt_pa_oe[POS_OPEN_DRAIN_PIN]  = ~pa_dir_ff[POS_OPEN_DRAIN_PIN]
                                   & ~pa_latch_ff[POS_OPEN_DRAIN_PIN]; // R4
    nxt_pb_out = pb_latch_ff;
    nxt_pb_oe  = ~pb_dir_ff; // R1
    if (i_prog_mode) begin
      nxt_pb_out[POS_PROG_CLK_PIN]  = 1'b0;
      nxt_pb_oe[POS_PROG_CLK_PIN]   = 1'b0; // R18
      nxt_pb_out[POS_PROG_DATA_PIN] = i_prog_data_out;
      nxt_pb_oe[POS_PROG_DATA_PIN]  = i_prog_data_oe; // R18
    end
    for (int i = 0; i < 6; i++) begin
      nxt_pc_dir[i] = i_pc_periph_en[i] ? ~i_pc_periph_dir_out[i] : pc_dir_ff[i]; // R20
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pa_out_ff  <= '0;
      pa_oe_ff   <= '0;
      pb_out_ff  <= '0;
      pb_oe_ff   <= '0;
      pb_pull_ff <= '0;
      pc_out_ff  <= '0;
      pc_oe_ff   <= '0;
    end else if (i_clk_en) begin
      pa_out_ff  <= nxt_pa_out;
      pa_oe_ff   <= nxt_pa_oe;
      pb_out_ff  <= nxt_pb_out;
      pb_oe_ff   <= nxt_pb_oe;
      // Pull-ups follow the actual driver state, so output pins lose them.
      pb_pull_ff <= {8{~option_ff[POS_PULLUP_ENABLE_N]}} & ~nxt_pb_oe; // R9 R10
      pc_out_ff  <= (i_pc_periph_en & i_pc_periph_out)
                  | (~i_pc_periph_en & pc_latch_ff); // R22
      pc_oe_ff   <= ~nxt_pc_dir; // R1 R20
    end
  end

  assign o_pa_out    = pa_out_ff;
  assign o_pa_oe     = pa_oe_ff;
  assign o_pb_out    = pb_out_ff;
  assign o_pb_oe     = pb_oe_ff;
  assign o_pb_pullup = pb_pull_ff;
  assign o_pc_out    = pc_out_ff;
  assign o_pc_oe     = pc_oe_ff;

  // ----------------------------------------------------------------------
  // Peripheral taps, change flag and wake.
  // ----------------------------------------------------------------------
  logic       t0_ff;
  logic       ext_int_ff;
  logic       prog_clk_ff;
  logic       prog_data_ff;
  logic [5:0] pc_in_ff;
  logic       wake_ff;
  logic       flag_out_ff;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      t0_ff        <= 1'b0;
      ext_int_ff   <= 1'b0;
      prog_clk_ff  <= 1'b0;
      prog_data_ff <= 1'b0;
      pc_in_ff     <= '0;
      wake_ff      <= 1'b0;
      flag_out_ff  <= 1'b0;
    end else if (i_clk_en) begin
      t0_ff        <= pa_sync_ff[POS_OPEN_DRAIN_PIN]; // R4
      ext_int_ff   <= pb_sync_ff[POS_EXT_INT_PIN]; // R17
      prog_clk_ff  <= i_prog_mode & pb_sync_ff[POS_PROG_CLK_PIN]; // R18
      prog_data_ff <= i_prog_mode & pb_sync_ff[POS_PROG_DATA_PIN]; // R18
      pc_in_ff     <= pc_sync_ff & i_pc_periph_en; // R22
      wake_ff      <= i_sleep & change_flag_ff; // R14
      flag_out_ff  <= change_flag_ff;
    end
  end

  assign o_timer0_ext_clock_in = t0_ff;
  assign o_ext_int_in          = ext_int_ff;
  assign o_prog_clk            = prog_clk_ff;
  assign o_prog_data           = prog_data_ff;
  assign o_pc_periph_in        = pc_in_ff;
  assign o_wake                = wake_ff;
  assign o_change_irq_flag     = flag_out_ff;

endmodule
`default_nettype wire

//--- dv/tpg_gpio_asserts.sv
// Checker of bus timing and pin relations at the GPIO block's ports.
`default_nettype none
module tpg_gpio_asserts
  import tpg_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_clk_en,
  input wire tpg_wb_req_t i_wb_req,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic [5:0]  i_pa_pin,
  input wire logic [5:0]  o_pa_out,
  input wire logic        o_timer0_ext_clock_in,
  input wire logic [7:0]  o_pb_oe,
  input wire logic [7:0]  o_pb_pullup,
  input wire logic        i_prog_mode,
  input wire logic [5:0]  o_pc_out,
  input wire logic [5:0]  o_pc_oe,
  input wire logic [5:0]  i_pc_periph_en,
  input wire logic [5:0]  i_pc_periph_dir_out,
  input wire logic [5:0]  i_pc_periph_out,
  input wire logic        i_sleep,
  input wire logic        o_change_irq_flag,
  input wire logic        o_wake
);
  // ----------------------------------------------------------------
  // Warm-up count: $past still sees reset-time inputs for a few edges.
  // ----------------------------------------------------------------
  logic [2:0] up_ff;
  logic       settled;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      up_ff <= 3'h0;
    end else if (!settled) begin
      up_ff <= up_ff + 3'h1;
    end
  end
  assign settled = (up_ff == 3'h7);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_req;
    i_wb_req.cyc && i_wb_req.stb && !o_wb_ack && i_clk_en;
  endsequence
  sequence s_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_answer;
    s_req |=> s_pulse;
  endproperty
  a_answer: assert property (p_answer) else $error("ack not one pulse after request");
  property p_dat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_od_low;
    o_pa_out[4] == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain pin driven high");
  property p_t0;
    settled |-> o_timer0_ext_clock_in == $past(i_pa_pin[4], 3);
  endproperty
  a_t0: assert property (p_t0) else $error("timer clock does not follow pin");
  property p_pull_out;
    (o_pb_pullup & o_pb_oe) == 8'h00;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull-up on output pin");
  property p_wake;
    o_wake == ($past(i_sleep) && o_change_irq_flag);
  endproperty
  a_wake: assert property (p_wake) else $error("wake does not follow flag");
  property p_pc_over;
    settled |-> (o_pc_oe & $past(i_pc_periph_en)) == $past(i_pc_periph_en & i_pc_periph_dir_out)
      && (o_pc_out & $past(i_pc_periph_en)) == $past(i_pc_periph_en & i_pc_periph_out);
  endproperty
  a_pc_over: assert property (p_pc_over) else $error("peripheral override lost");
  property p_prog;
    settled && $past(i_prog_mode) |-> !o_pb_oe[6];
  endproperty
  a_prog: assert property (p_prog) else $error("programming clock pin driven");
endmodule
bind tpg_gpio tpg_gpio_asserts chk_u (
  .i_sys_clk, .i_rst, .i_clk_en, .i_wb_req, .o_wb_ack, .o_wb_dat, .i_pa_pin, .o_pa_out,
  .o_timer0_ext_clock_in, .o_pb_oe, .o_pb_pullup, .i_prog_mode, .o_pc_out, .o_pc_oe,
  .i_pc_periph_en, .i_pc_periph_dir_out, .i_pc_periph_out, .i_sleep, .o_change_irq_flag,
  .o_wake
);
`default_nettype wire

//--- dv/tpg_pin_env.sv
// Model of the external circuitry on the three ports' pins.
`default_nettype none
module tpg_pin_env (
  input wire logic       i_clk,
  input wire logic [5:0] i_pa_out,
  input wire logic [5:0] i_pa_oe,
  input wire logic [5:0] i_pa_ext,
  input wire logic [7:0] i_pb_out,
  input wire logic [7:0] i_pb_oe,
  input wire logic [7:0] i_pb_pullup,
  input wire logic [7:0] i_pb_ext,
  input wire logic [7:0] i_pb_ext_en,
  input wire logic [5:0] i_pc_out,
  input wire logic [5:0] i_pc_oe,
  input wire logic [5:0] i_pc_ext,
  output logic [5:0]     o_pa_pin,
  output logic [7:0]     o_pb_pin,
  output logic [5:0]     o_pc_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating line toggles, so a stale level can never pass for a real one.
  logic [7:0] float_ff = 8'h55;
  always_ff @(posedge i_clk) begin
    float_ff <= ~float_ff;
  end
  // External drivers are resistive: the device wins wherever it drives.
  assign o_pa_pin = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_pa_ext);
  assign o_pb_pin = (i_pb_oe & i_pb_out) | (~i_pb_oe & i_pb_ext_en & i_pb_ext)
                  | (~i_pb_oe & ~i_pb_ext_en & (i_pb_pullup | float_ff));
  assign o_pc_pin = (i_pc_oe & i_pc_out) | (~i_pc_oe & i_pc_ext);
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the three-port GPIO block.
`default_nettype none
module tb
  import tpg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  tpg_wb_req_t i_wb_req = '0;
  logic        o_wb_ack, o_timer0_ext_clock_in, o_ext_int_in, o_prog_clk, o_prog_data;
  logic        o_change_irq_flag, o_wake;
  logic [31:0] o_wb_dat;
  logic [5:0]  i_pa_pin, o_pa_out, o_pa_oe, i_pc_pin, o_pc_out, o_pc_oe, o_pc_periph_in;
  logic [7:0]  i_pb_pin, o_pb_out, o_pb_oe, o_pb_pullup;
  logic        i_prog_mode = 1'b0, i_prog_data_out = 1'b0, i_prog_data_oe = 1'b0;
  logic        i_sleep = 1'b0;
  logic [5:0]  i_pc_periph_en = 6'h0, i_pc_periph_dir_out = 6'h0, i_pc_periph_out = 6'h0;
  logic [5:0]  ext_a = 6'h0, ext_c = 6'h0;
  logic [7:0]  ext_b = 8'h0, ext_b_en = 8'hFF;
  int          n_mismatch = 0;
  int          compares = 0;
  logic [7:0]  rst_idx [7] = '{IDX_OPTION_CONTROL, IDX_PORT_A_DIRECTION, IDX_PORT_B_DIRECTION,
    IDX_PORT_C_DIRECTION, IDX_ANALOG_PIN_CFG, IDX_INTERRUPT_CTRL, 8'hFF};
  logic [7:0]  rst_val [7] = '{8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00};
  always #10 i_sys_clk = ~i_sys_clk;
  tpg_gpio dut_u (
    .i_sys_clk, .i_rst, .i_clk_en(1'b1), .i_wb_req, .o_wb_ack, .o_wb_dat,
    .i_pa_pin, .o_pa_out, .o_pa_oe, .o_timer0_ext_clock_in,
    .i_pb_pin, .o_pb_out, .o_pb_oe, .o_pb_pullup, .o_ext_int_in,
    .i_prog_mode, .i_prog_data_out, .i_prog_data_oe, .o_prog_clk, .o_prog_data,
    .i_pc_pin, .o_pc_out, .o_pc_oe, .i_pc_periph_en, .i_pc_periph_dir_out,
    .i_pc_periph_out, .o_pc_periph_in, .i_sleep, .o_change_irq_flag, .o_wake
  );
  tpg_pin_env env_u (
    .i_clk(i_sys_clk), .i_pa_out(o_pa_out), .i_pa_oe(o_pa_oe), .i_pa_ext(ext_a),
    .i_pb_out(o_pb_out), .i_pb_oe(o_pb_oe), .i_pb_pullup(o_pb_pullup), .i_pb_ext(ext_b),
    .i_pb_ext_en(ext_b_en), .i_pc_out(o_pc_out), .i_pc_oe(o_pc_oe), .i_pc_ext(ext_c),
    .o_pa_pin(i_pa_pin), .o_pb_pin(i_pb_pin), .o_pc_pin(i_pc_pin)
  );
  // ----------------------------------------------------------------
  // Checks and bus cycles
  // ----------------------------------------------------------------
  task automatic bad(input string m);
    n_mismatch++;
    $display("ERROR t=%0t %s", $time, m);
  endtask
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) bad($sformatf("read %h expected %h", got, exp));
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) bad($sformatf("pins %h expected %h", got, exp));
  endtask
  // Ack is sampled at the rising edge; data is taken and the request dropped at that edge.
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, sel, {24'h00_0000, d}};
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) bad("bus answer missing");
    q = o_wb_dat;
    i_wb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, 4'h1, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, 4'h1, q);
    chk_bus(q, {24'h00_0000, e});
  endtask
  // Pin to flag output takes two sync stages, the flag and its copy: allow six edges.
  task automatic settle();
    repeat (6) @(posedge i_sys_clk);
  endtask
  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200_000;
    bad("watchdog expired");
    summarize();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic [5:0]  m;
    logic [5:0]  oe_c;
    logic [5:0]  pin_c;
    void'($urandom(32'hc2fe));
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    ext_a <= 6'h3F;
    for (int k = 0; k < 7; k++) begin
      rd(rst_idx[k], rst_val[k]);
    end
    chk_pin(o_pb_pullup, 8'h00);
    rd(IDX_PORT_A_DATA, 8'h10);
    $display("test reset done");
    // Direction bits stay set while pins are analog.
    for (int c = 0; c < 8; c++) begin
      r = $urandom;
      ext_a <= r[5:0];
      wr(IDX_ANALOG_PIN_CFG, 8'(c));
      settle();
      m = (c == 0) ? MASK_ANALOG_ALL : (c == 1) ? MASK_ANALOG_REF :
          (c > 5) ? MASK_ANALOG_NONE : MASK_ANALOG_LOW;
      rd(IDX_PORT_A_DATA, {2'b00, r[5:0] & ~m});
    end
    $display("test analog done");
    r = $urandom;
    ext_a <= r[5:0];
    settle();
    wb(1'b1, IDX_PORT_A_DATA, ~r[7:0], 4'h0, q);
    wr(IDX_PORT_A_DIRECTION, 8'h00);
    settle();
    chk_pin({2'b00, o_pa_out}, {2'b00, r[5:0] & 6'h2F});
    for (int k = 0; k < 3; k++) begin
      r = $urandom;
      wr(IDX_PORT_A_DATA, r[7:0]);
      settle();
      chk_pin({2'b00, o_pa_oe}, {2'b00, 1'b1, ~r[4], 4'hF});
      rd(IDX_PORT_A_DATA, {2'b00, r[5], r[4] & ext_a[4], r[3:0]});
    end
    $display("test port_a done");
    wr(IDX_OPTION_CONTROL, 8'h7F);
    wr(IDX_PORT_B_DIRECTION, 8'hF0);
    wr(IDX_PORT_B_DATA, 8'h05);
    ext_b_en <= 8'h00;
    settle();
    chk_pin(o_pb_pullup, 8'hF0);
    rd(IDX_PORT_B_DATA, 8'hF5);
    wr(IDX_OPTION_CONTROL, 8'hFF);
    ext_b <= 8'hA0;
    ext_b_en <= 8'hFF;
    settle();
    chk_pin(o_pb_pullup, 8'h00);
    $display("test pullup done");
    rd(IDX_PORT_B_DATA, 8'hA5);
    wr(IDX_INTERRUPT_CTRL, 8'h00);
    i_sleep <= 1'b1;
    // No port B access until the flag has been seen.
    ext_b <= 8'h20;
    settle();
    chk_pin({6'h00, o_change_irq_flag, o_wake}, 8'h03);
    rd(IDX_INTERRUPT_CTRL, 8'h01);
    wr(IDX_INTERRUPT_CTRL, 8'h00);
    settle();
    chk_pin({7'h00, o_change_irq_flag}, 8'h01);
    rd(IDX_PORT_B_DATA, 8'h25);
    wr(IDX_INTERRUPT_CTRL, 8'h00);
    settle();
    chk_pin({6'h00, o_change_irq_flag, o_wake}, 8'h00);
    wr(IDX_PORT_B_DATA, 8'h15);
    wr(IDX_PORT_B_DIRECTION, 8'hE0);
    settle();
    chk_pin({6'h00, o_change_irq_flag, o_ext_int_in}, 8'h01);
    i_sleep <= 1'b0;
    $display("test change done");
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      q = $urandom;
      i_pc_periph_en <= r[5:0];
      i_pc_periph_dir_out <= r[11:6];
      i_pc_periph_out <= r[17:12];
      ext_c <= r[23:18];
      wr(IDX_PORT_C_DIRECTION, {2'b00, q[5:0]});
      wr(IDX_PORT_C_DATA, q[15:8]);
      settle();
      oe_c = (r[5:0] & r[11:6]) | (~r[5:0] & ~q[5:0]);
      pin_c = (oe_c & ((r[5:0] & r[17:12]) | (~r[5:0] & q[13:8]))) | (~oe_c & r[23:18]);
      chk_pin({2'b00, o_pc_oe}, {2'b00, oe_c});
      chk_pin({2'b00, o_pc_periph_in}, {2'b00, pin_c & r[5:0]});
      rd(IDX_PORT_C_DATA, {2'b00, pin_c});
    end
    $display("test port_c done");
    i_prog_mode <= 1'b1;
    i_prog_data_out <= 1'b1;
    i_prog_data_oe <= 1'b1;
    ext_b <= 8'h40;
    settle();
    chk_pin({o_pb_oe[7:6], o_prog_clk, o_prog_data, 4'h0}, 8'hB0);
    i_prog_mode <= 1'b0;
    $display("test prog done");
    summarize();
  end
endmodule
`default_nettype wire
